/* File: interval_counter.sv */
// One 8-bit up-counter with compare-match clear
`timescale 1ns/1ps
`default_nettype none
module interval_counter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [interval_timer_pkg::CNT_W-1:0] match_value_i,
  output logic [interval_timer_pkg::CNT_W-1:0] count_o,
  output logic match_o
);
  import interval_timer_pkg::*;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= COUNT_RESET;
      match_o <= 1'b0;
    end else if (ce_i) begin
      match_o <= 1'b0;
      if (!run_i) begin
        count_o <= COUNT_RESET;
      end else if (tick_i) begin
        // Compare uses the live register, so a rewrite while running can hit at once
        if (count_o == match_value_i) begin
          count_o <= COUNT_RESET;
          match_o <= 1'b1;
        end else begin
          count_o <= count_o + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule : interval_counter
`default_nettype wire

/* File: interval_timer_pkg.sv */
// Constants shared by the triple interval timer block
package interval_timer_pkg;

  localparam int CNT_W = 8;
  localparam int ADDR_W = 16;
  localparam int NCH = 3;
  localparam int PRE_W = 10;

  // Register addresses
  localparam logic [15:0] MODE_CTRL_CH0_ADDR = 16'hff59;
  localparam logic [15:0] MODE_CTRL_CH1_ADDR = 16'hff5c;
  localparam logic [15:0] MODE_CTRL_CH2_ADDR = 16'hff5f;
  localparam logic [15:0] MATCH_VALUE_CH0_ADDR = 16'hff50;
  localparam logic [15:0] MATCH_VALUE_CH1_ADDR = 16'hff51;
  localparam logic [15:0] MATCH_VALUE_CH2_ADDR = 16'hff52;
  localparam logic [15:0] COUNT_VALUE_CH0_ADDR = 16'hff54;
  localparam logic [15:0] COUNT_VALUE_CH1_ADDR = 16'hff55;
  localparam logic [15:0] COUNT_VALUE_CH2_ADDR = 16'hff56;

  // Mode control field positions
  localparam int RUN_BIT = 7;
  localparam int SEL_HI_BIT = 2;
  localparam int SEL_LO_BIT = 1;
  localparam int OUT_EN_BIT = 0;

  // Writable bits; the rest read as zero
  localparam logic [7:0] MODE_MASK_CH01 = 8'h86;
  localparam logic [7:0] MODE_MASK_CH2 = 8'h87;

  // Values after reset, and read data of unmapped addresses
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

  // Clock field codes
  localparam logic [1:0] SEL_DIV_A = 2'h0;
  localparam logic [1:0] SEL_DIV_B = 2'h1;
  localparam logic [1:0] SEL_EXT_RISE = 2'h2;
  localparam logic [1:0] SEL_EXT_FALL = 2'h3;

  // Prescaler exponents per channel, main clock divided by 2^N
  localparam int CH0_DIV_A_EXP = 6;
  localparam int CH0_DIV_B_EXP = 9;
  localparam int CH1_DIV_A_EXP = 4;
  localparam int CH1_DIV_B_EXP = 8;
  localparam int CH2_DIV_A_EXP = 3;
  localparam int CH2_DIV_B_EXP = 10;

endpackage : interval_timer_pkg

/* File: prescale_ticks.sv */
// Main clock prescaler and subsystem clock edge detector
`timescale 1ns/1ps
`default_nettype none
module prescale_ticks (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sub_clk_i,
  output logic [interval_timer_pkg::PRE_W-1:0] div_tick_o,
  output logic sub_tick_o
);
  import interval_timer_pkg::*;

  logic [PRE_W-1:0] pre_q;
  logic [2:0] sub_sync_q;

  // Bit i pulses once every 2^(i+1) clocks
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_q <= '0;
      div_tick_o <= '0;
    end else if (ce_i) begin
      pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
      for (int i = 0; i < PRE_W; i++) begin
        div_tick_o[i] <= &(pre_q | ~PRE_W'((1 << (i + 1)) - 1));
      end
    end
  end

  // Subsystem clock is slow and asynchronous: two stages, then edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sub_sync_q <= '0;
      sub_tick_o <= 1'b0;
    end else if (ce_i) begin
      sub_sync_q <= {sub_sync_q[1:0], sub_clk_i};
      sub_tick_o <= sub_sync_q[1] & ~sub_sync_q[2];
    end
  end

endmodule : prescale_ticks
`default_nettype wire

/* File: timer_far_side.sv */
// Event pulse source, subsystem oscillator and timer output load
`timescale 1ns/1ps
`default_nettype none
module timer_far_side (
  input wire logic clk_i,
  input wire logic timer_out_pin_i,
  output logic event_pin_o,
  output logic sub_clk_o
);
  int n_edges = 0;
  initial begin
    event_pin_o = 1'b0;
    sub_clk_o = 1'b0;
  end
  // Free-running slow oscillator, unrelated in phase to clk_i
  always #51.5 sub_clk_o = ~sub_clk_o;
  always @(posedge timer_out_pin_i) n_edges++;
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk_i);
      event_pin_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      event_pin_o <= 1'b0;
    end
  endtask : pulse
endmodule : timer_far_side
`default_nettype wire

/* File: triple_8bit_interval_timer.sv */
// Top of the three-channel 8-bit interval timer with register port
`timescale 1ns/1ps
`default_nettype none
module triple_8bit_interval_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [interval_timer_pkg::ADDR_W-1:0] addr_i,
  input wire logic wr_byte_i,
  input wire logic wr_bit_i,
  input wire logic [2:0] bit_idx_i,
  input wire logic bit_val_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_i,
  input wire logic event_in_pin_i,
  input wire logic sub_clk_i,
  output logic [7:0] rdata_o,
  output logic [interval_timer_pkg::NCH-1:0] match_irq_o,
  output logic timer_out_pin_o,
  output logic timer_out_oe_o
);
  import interval_timer_pkg::*;

  // Register contents
  logic [7:0] mode_ctrl_ch0_q;
  logic [7:0] mode_ctrl_ch1_q;
  logic [7:0] mode_ctrl_ch2_q;
  logic [7:0] match_value_ch0_q;
  logic [7:0] match_value_ch1_q;
  logic [7:0] match_value_ch2_q;
  logic [7:0] mode_ctrl_ch0_d;
  logic [7:0] mode_ctrl_ch1_d;
  logic [7:0] mode_ctrl_ch2_d;
  logic [7:0] rdata_d;

  // Counter state
  logic [CNT_W-1:0] count_value_ch0;
  logic [CNT_W-1:0] count_value_ch1;
  logic [CNT_W-1:0] count_value_ch2;

  // Clock sources
  logic [PRE_W-1:0] div_tick;
  logic sub_tick;
  logic event_q;
  logic event_rise_q;
  logic event_fall_q;
  logic [NCH-1:0] tick;
  logic [NCH-1:0] run;

  // Timer output
  logic out_level_q;
  logic out_level_d;
  logic out_enable;

  // Address decodes
  logic sel_mode0;
  logic sel_mode1;
  logic sel_mode2;
  logic sel_match0;
  logic sel_match1;
  logic sel_match2;

  // Byte write replaces, bit write changes one bit; only writable bits stored
  function automatic logic [7:0] merge_write(
    input logic [7:0] old_val,
    input logic byte_we,
    input logic bit_we,
    input logic [2:0] idx,
    input logic val,
    input logic [7:0] wdata,
    input logic [7:0] mask
  );
    logic [7:0] nxt;
    nxt = old_val;
    if (byte_we) begin
      nxt = wdata;
    end else if (bit_we) begin
      nxt[idx] = val;
    end
    return nxt & mask;
  endfunction : merge_write

  // Picks the count pulse for a channel from its clock field
  function automatic logic pick_tick(
    input logic [1:0] sel,
    input logic div_a,
    input logic div_b,
    input logic alt_rise,
    input logic alt_fall
  );
    logic t;
    t = 1'b0;
    unique case (sel)
      SEL_DIV_A: t = div_a;
      SEL_DIV_B: t = div_b;
      SEL_EXT_RISE: t = alt_rise;
      SEL_EXT_FALL: t = alt_fall;
    endcase
    return t;
  endfunction : pick_tick

  assign sel_mode0 = (addr_i == MODE_CTRL_CH0_ADDR);
  assign sel_mode1 = (addr_i == MODE_CTRL_CH1_ADDR);
  assign sel_mode2 = (addr_i == MODE_CTRL_CH2_ADDR);
  assign sel_match0 = (addr_i == MATCH_VALUE_CH0_ADDR);
  assign sel_match1 = (addr_i == MATCH_VALUE_CH1_ADDR);
  assign sel_match2 = (addr_i == MATCH_VALUE_CH2_ADDR);

  // Next mode values; bits 3..6, and bit 0 of channels 0 and 1, are never stored
  always_comb begin
    mode_ctrl_ch0_d = mode_ctrl_ch0_q;
    mode_ctrl_ch1_d = mode_ctrl_ch1_q;
    mode_ctrl_ch2_d = mode_ctrl_ch2_q;
    if (sel_mode0) begin
      mode_ctrl_ch0_d = merge_write(mode_ctrl_ch0_q, wr_byte_i, wr_bit_i, bit_idx_i,
                                    bit_val_i, wdata_i, MODE_MASK_CH01);
    end
    if (sel_mode1) begin
      mode_ctrl_ch1_d = merge_write(mode_ctrl_ch1_q, wr_byte_i, wr_bit_i, bit_idx_i,
                                    bit_val_i, wdata_i, MODE_MASK_CH01);
    end
    if (sel_mode2) begin
      mode_ctrl_ch2_d = merge_write(mode_ctrl_ch2_q, wr_byte_i, wr_bit_i, bit_idx_i,
                                    bit_val_i, wdata_i, MODE_MASK_CH2);
    end
  end

  // Mode control registers, frozen while the clock enable is low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_ctrl_ch0_q <= MODE_RESET;
      mode_ctrl_ch1_q <= MODE_RESET;
      mode_ctrl_ch2_q <= MODE_RESET;
    end else if (ce_i) begin
      mode_ctrl_ch0_q <= mode_ctrl_ch0_d;
      mode_ctrl_ch1_q <= mode_ctrl_ch1_d;
      mode_ctrl_ch2_q <= mode_ctrl_ch2_d;
    end
  end

  // Compare registers: no reset, whole-byte writes only, bit writes dropped
  // Left unreset: software must load them before starting a channel
  always_ff @(posedge clk_i) begin
    if (ce_i && wr_byte_i) begin
      if (sel_match0) begin
        match_value_ch0_q <= wdata_i;
      end
      if (sel_match1) begin
        match_value_ch1_q <= wdata_i;
      end
      if (sel_match2) begin
        match_value_ch2_q <= wdata_i;
      end
    end
  end

  // Read data of the addressed register; unmapped addresses read zero
  always_comb begin
    unique case (addr_i)
      MODE_CTRL_CH0_ADDR: rdata_d = mode_ctrl_ch0_q;
      MODE_CTRL_CH1_ADDR: rdata_d = mode_ctrl_ch1_q;
      MODE_CTRL_CH2_ADDR: rdata_d = mode_ctrl_ch2_q;
      MATCH_VALUE_CH0_ADDR: rdata_d = match_value_ch0_q;
      MATCH_VALUE_CH1_ADDR: rdata_d = match_value_ch1_q;
      MATCH_VALUE_CH2_ADDR: rdata_d = match_value_ch2_q;
      COUNT_VALUE_CH0_ADDR: rdata_d = count_value_ch0;
      COUNT_VALUE_CH1_ADDR: rdata_d = count_value_ch1;
      COUNT_VALUE_CH2_ADDR: rdata_d = count_value_ch2;
      default: rdata_d = UNMAPPED_RDATA;
    endcase
  end

  // Read port answers one cycle after the strobe and holds until the next read
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= RDATA_RESET;
    end else if (ce_i && rd_i) begin
      rdata_o <= rdata_d;
    end
  end

  // Event input is synchronous to clk_i; detect both edges
  // Registered edge pulses give channel 0 one tick per rising edge (code 10) or per falling edge (code 11)
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      event_q <= 1'b0;
      event_rise_q <= 1'b0;
      event_fall_q <= 1'b0;
    end else if (ce_i) begin
      event_q <= event_in_pin_i;
      event_rise_q <= event_in_pin_i & ~event_q;
      event_fall_q <= ~event_in_pin_i & event_q;
    end
  end

  prescale_ticks u_prescale (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .sub_clk_i(sub_clk_i),
    .div_tick_o(div_tick),
    .sub_tick_o(sub_tick)
  );

  assign run[0] = mode_ctrl_ch0_q[RUN_BIT];
  assign run[1] = mode_ctrl_ch1_q[RUN_BIT];
  assign run[2] = mode_ctrl_ch2_q[RUN_BIT];

  assign tick[0] = pick_tick(mode_ctrl_ch0_q[SEL_HI_BIT:SEL_LO_BIT],
                             div_tick[CH0_DIV_A_EXP-1], div_tick[CH0_DIV_B_EXP-1],
                             event_rise_q, event_fall_q);
  // Codes 10 and 11 both take the subsystem clock
  assign tick[1] = pick_tick(mode_ctrl_ch1_q[SEL_HI_BIT:SEL_LO_BIT],
                             div_tick[CH1_DIV_A_EXP-1], div_tick[CH1_DIV_B_EXP-1],
                             sub_tick, sub_tick);
  assign tick[2] = pick_tick(mode_ctrl_ch2_q[SEL_HI_BIT:SEL_LO_BIT],
                             div_tick[CH2_DIV_A_EXP-1], div_tick[CH2_DIV_B_EXP-1],
                             sub_tick, sub_tick);

  interval_counter u_cnt0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(run[0]),
    .tick_i(tick[0]),
    .match_value_i(match_value_ch0_q),
    .count_o(count_value_ch0),
    .match_o(match_irq_o[0])
  );

  interval_counter u_cnt1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(run[1]),
    .tick_i(tick[1]),
    .match_value_i(match_value_ch1_q),
    .count_o(count_value_ch1),
    .match_o(match_irq_o[1])
  );

  interval_counter u_cnt2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(run[2]),
    .tick_i(tick[2]),
    .match_value_i(match_value_ch2_q),
    .count_o(count_value_ch2),
    .match_o(match_irq_o[2])
  );

  // Square wave: toggles on each channel 2 match, held low while stopped
  always_comb begin
    out_level_d = out_level_q;
    if (!run[2]) begin
      out_level_d = 1'b0;
    end else if (match_irq_o[2]) begin
      out_level_d = ~out_level_q;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_level_q <= 1'b0;
    end else if (ce_i) begin
      out_level_q <= out_level_d;
    end
  end

  assign out_enable = mode_ctrl_ch2_q[OUT_EN_BIT];

  // Pin driver: enable follows the output enable bit, level follows the wave
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_out_pin_o <= 1'b0;
      timer_out_oe_o <= 1'b0;
    end else if (ce_i) begin
      timer_out_oe_o <= out_enable;
      timer_out_pin_o <= out_enable & out_level_q;
    end
  end

endmodule : triple_8bit_interval_timer
`default_nettype wire

/* File: triple_8bit_interval_timer_assertions.sv */
// Checker of the timer's register port, interrupts and output pin
`timescale 1ns/1ps
`default_nettype none
module timer_assertions
  import interval_timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_byte_i,
  input wire logic wr_bit_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [2:0] match_irq_o,
  input wire logic timer_out_pin_o,
  input wire logic timer_out_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_irq_one_cycle: assert property (|match_irq_o |=> (match_irq_o & $past(match_irq_o)) == 3'h0)
    else $error("match interrupt longer than one cycle");
  a_oe_follows_mode: assert property (wr_byte_i && addr_i == MODE_CTRL_CH2_ADDR
    |-> ##2 {7'h00, timer_out_oe_o} == ($past(wdata_i, 2) & 8'h01))
    else $error("output enable not taken from mode write");
  a_pin_gated: assert property (!timer_out_oe_o |-> !timer_out_pin_o)
    else $error("pin driven while output disabled");
  a_pin_toggles: assert property (!wr_byte_i ##1 match_irq_o[2] && !wr_byte_i
    && timer_out_oe_o ##1 timer_out_oe_o && !wr_byte_i ##1 timer_out_oe_o
    |-> $changed(timer_out_pin_o))
    else $error("pin did not toggle after channel 2 match");
  a_stop_quiet: assert property (wr_byte_i && addr_i == MODE_CTRL_CH0_ADDR && !wdata_i[7]
    |-> ##2 !match_irq_o[0] [*2])
    else $error("stopped channel 0 raised a match");
  a_rdata_holds: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (rd_i && addr_i[15:8] != 8'hff |=> rdata_o == UNMAPPED_RDATA)
    else $error("unmapped read not zero");
  a_mode_readback: assert property (wr_byte_i && addr_i == MODE_CTRL_CH1_ADDR ##1
    !wr_byte_i && !wr_bit_i ##1 rd_i && addr_i == MODE_CTRL_CH1_ADDR
    |=> rdata_o == ($past(wdata_i, 3) & MODE_MASK_CH01))
    else $error("mode readback wrong");

  c_irq0: cover property (match_irq_o[0]);
  c_pin_high: cover property (timer_out_oe_o && $rose(timer_out_pin_o));
  c_unmapped: cover property (rd_i && addr_i[15:8] != 8'hff);
endmodule : timer_assertions

bind triple_8bit_interval_timer timer_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wr_byte_i(wr_byte_i), .wr_bit_i(wr_bit_i), .wdata_i(wdata_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .match_irq_o(match_irq_o),
  .timer_out_pin_o(timer_out_pin_o), .timer_out_oe_o(timer_out_oe_o));
`default_nettype wire

/* File: triple_8bit_interval_timer_tb.sv */
// Self-checking bench of the triple interval timer
`timescale 1ns/1ps
`default_nettype none
module triple_8bit_interval_timer_tb;
  import interval_timer_pkg::*;
  logic clk_i = 0, rst_i = 1, ce_i = 1, wr_byte_i = 0, wr_bit_i = 0, bit_val_i = 0, rd_i = 0;
  logic [15:0] addr_i = '0;
  logic [2:0] bit_idx_i = '0, match_irq_o;
  logic [7:0] wdata_i = '0, rdata_o, d;
  logic timer_out_pin_o, timer_out_oe_o, event_in_pin_i, sub_clk_i;
  int miscompares = 0, n_checks = 0, seed = 41367, per, irq_cnt[3] = '{0, 0, 0};
  logic [7:0] mdl_mode[3];
  logic [15:0] mode_a[3] = '{MODE_CTRL_CH0_ADDR, MODE_CTRL_CH1_ADDR, MODE_CTRL_CH2_ADDR};
  logic [15:0] match_a[3] = '{MATCH_VALUE_CH0_ADDR, MATCH_VALUE_CH1_ADDR, MATCH_VALUE_CH2_ADDR};
  logic [15:0] cnt_a[3] = '{COUNT_VALUE_CH0_ADDR, COUNT_VALUE_CH1_ADDR, COUNT_VALUE_CH2_ADDR};
  // Channel, clock code, match value, prescaler exponent
  int tab[7][4] = '{'{2, 0, 3, CH2_DIV_A_EXP}, '{1, 0, 2, CH1_DIV_A_EXP},
    '{0, 0, 1, CH0_DIV_A_EXP}, '{2, 1, 0, CH2_DIV_B_EXP}, '{1, 1, 0, CH1_DIV_B_EXP},
    '{0, 1, 0, CH0_DIV_B_EXP}, '{2, 0, 255, CH2_DIV_A_EXP}};

  triple_8bit_interval_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .addr_i(addr_i), .wr_byte_i(wr_byte_i), .wr_bit_i(wr_bit_i), .bit_idx_i(bit_idx_i),
    .bit_val_i(bit_val_i), .wdata_i(wdata_i), .rd_i(rd_i), .event_in_pin_i(event_in_pin_i),
    .sub_clk_i(sub_clk_i), .rdata_o(rdata_o), .match_irq_o(match_irq_o),
    .timer_out_pin_o(timer_out_pin_o), .timer_out_oe_o(timer_out_oe_o));
  timer_far_side u_far (.clk_i(clk_i), .timer_out_pin_i(timer_out_pin_o),
    .event_pin_o(event_in_pin_i), .sub_clk_o(sub_clk_i));

  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) if (match_irq_o[i] === 1'b1) irq_cnt[i]++;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_byte_i <= 1'b1;
    @(posedge clk_i);
    wr_byte_i <= 1'b0;
  endtask : wr
  task automatic wrb(input logic [15:0] a, input logic [2:0] i, input logic v);
    @(posedge clk_i);
    addr_i <= a;
    bit_idx_i <= i;
    bit_val_i <= v;
    wr_bit_i <= 1'b1;
    @(posedge clk_i);
    wr_bit_i <= 1'b0;
  endtask : wrb
  task automatic rd(input logic [15:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    d = rdata_o;
  endtask : rd
  task automatic setm(input int c, input logic [7:0] v);
    wr(mode_a[c], v);
    mdl_mode[c] = v & (c == 2 ? MODE_MASK_CH2 : MODE_MASK_CH01);
  endtask : setm
  task automatic run(input int c, input logic [1:0] s, input logic [7:0] m);
    setm(c, 8'h00);
    wr(match_a[c], m);
    setm(c, {5'h00, s, 1'b1});
    wrb(mode_a[c], 3'h7, 1'b1);
    mdl_mode[c][7] = 1'b1;
  endtask : run
  task automatic wait_irq(input int c);
    per = 0;
    do begin
      @(posedge clk_i);
      per++;
    end while (match_irq_o[c] !== 1'b1 && per < 5000);
    if (per >= 5000) begin
      miscompares++;
      close_out();
    end
  endtask : wait_irq

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int c = 0; c < 3; c++) begin
      rd(mode_a[c]);
      chk("mode reset", 16'h0000, d);
      rd(cnt_a[c]);
      chk("count reset", 16'h0000, d);
      setm(c, 8'($random(seed)) & 8'h07);
      rd(mode_a[c]);
      chk("mode write", mdl_mode[c], d);
      wrb(mode_a[c], 3'h2, 1'b1);
      mdl_mode[c][2] = 1'b1;
      rd(mode_a[c]);
      chk("mode bit", mdl_mode[c], d);
    end
    wr(match_a[1], 8'h5a);
    wrb(match_a[1], 3'h0, 1'b1);
    rd(match_a[1]);
    chk("match bit write", 16'h005a, d);
    wr(cnt_a[0], 8'h33);
    rd(cnt_a[0]);
    chk("count write", 16'h0000, d);
    rd(16'h1234);
    chk("unmapped", 16'h0000, d);
    $display("register test done");
    foreach (tab[i]) begin
      run(tab[i][0], 2'(tab[i][1]), 8'(tab[i][2]));
      wait_irq(tab[i][0]);
      wait_irq(tab[i][0]);
      chk("interval", 16'((tab[i][2] + 1) << tab[i][3]), 16'(per));
      setm(tab[i][0], 8'h00);
      rd(cnt_a[tab[i][0]]);
      chk("stopped count", 16'h0000, d);
    end
    $display("interval test done");
    for (int s = 2; s < 4; s++) begin
      run(0, 2'(s), 8'h02);
      per = irq_cnt[0];
      u_far.pulse(6);
      repeat (8) @(posedge clk_i);
      chk("event matches", 16'h0002, 16'(irq_cnt[0] - per));
    end
    $display("event test done");
    for (int c = 1; c < 3; c++) begin
      run(c, 2'(c + 1), 8'h00);
      per = irq_cnt[c];
      repeat (400) @(posedge clk_i);
      chk("sub ticks", 16'h0001, 16'((irq_cnt[c] - per) inside {[18:21]}));
      setm(c, 8'h00);
    end
    $display("subsystem test done");
    run(2, SEL_DIV_A, 8'hff);
    rd(cnt_a[2]);
    per = int'(d);
    @(posedge clk_i);
    ce_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    ce_i <= 1'b1;
    rd(cnt_a[2]);
    chk("frozen count", 16'h0001, 16'((int'(d) - per) inside {[0:1]}));
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(mode_a[2]);
    chk("mode mid reset", 16'h0000, d);
    rd(cnt_a[2]);
    chk("count mid reset", 16'h0000, d);
    $display("clock enable and reset test done");
    run(2, SEL_DIV_A, 8'h03);
    per = u_far.n_edges;
    repeat (640) @(posedge clk_i);
    chk("pin edges", 16'h0001, 16'((u_far.n_edges - per) inside {[9:11]}));
    chk("oe on", 16'h0001, {15'h0000, timer_out_oe_o});
    setm(2, 8'h01);
    repeat (4) @(posedge clk_i);
    chk("pin stopped", 16'h0000, {15'h0000, timer_out_pin_o});
    setm(2, 8'h00);
    repeat (3) @(posedge clk_i);
    chk("oe off", 16'h0000, {15'h0000, timer_out_oe_o});
    $display("output test done");
    close_out();
  end
endmodule : triple_8bit_interval_timer_tb
`default_nettype wire
